// File: core/rscd_pkg.sv
package rscd_pkg;
	// strap bit positions in the capture registers
	localparam int unsigned REFERENCE_CRYSTAL_BIT   = 3;
	localparam int unsigned MODE1_BIT  = 7;
	localparam int unsigned SUB3_BIT   = 8;
	localparam int unsigned SUB4_BIT   = 9;
	localparam int unsigned NOWAIT_BIT = 10;
	localparam int unsigned MODE0_BIT  = 11;
	localparam int unsigned SUB0_BIT   = 12;
	localparam int unsigned SUB1_BIT   = 13;
	localparam int unsigned SUB2_BIT   = 14;

	localparam int unsigned STRAP_W    = 16;
	localparam int unsigned PIN_COUNT  = 9;
	localparam logic [15:0] STRAP_RST  = 16'h0000;

	// operating mode encodings
	localparam logic [1:0] OPMD_RESERVED = 2'h0;
	localparam logic [1:0] OPMD_UNMANAGED = 2'h1;
	localparam logic [1:0] OPMD_SPI      = 2'h2;
	localparam logic [1:0] OPMD_MDIO     = 2'h3;

	// slave management port addresses
	localparam logic [4:0] MDIO_ADDR_0 = 5'h00;
	localparam logic [4:0] MDIO_ADDR_1 = 5'h04;
	localparam logic [4:0] MDIO_ADDR_2 = 5'h10;
	localparam logic [4:0] MDIO_ADDR_3 = 5'h1F;

	// reference crystal figures in MHz
	localparam int unsigned REFERENCE_CRYSTAL_MHZ_0 = 40;
	localparam int unsigned REFERENCE_CRYSTAL_MHZ_1 = 25;

	// register byte offsets
	localparam logic [11:0] OFS_STRAP_LOW  = 12'h000;
	localparam logic [11:0] OFS_STRAP_HIGH = 12'h004;
	localparam logic [11:0] OFS_STATUS     = 12'h008;
	localparam logic [11:0] OFS_CONTROL    = 12'h00C;
	localparam logic [11:0] OFS_CONFIG     = 12'h010;

	// status fields
	localparam int unsigned ST_CAPTURED = 0;
	localparam int unsigned ST_PLL_RUN  = 1;
	localparam int unsigned ST_PULLUP   = 2;
	localparam int unsigned ST_BOOT     = 3;
	localparam int unsigned ST_RESV_MD  = 4;
	localparam int unsigned ST_HW_LEVEL = 5;
	// control fields
	localparam int unsigned CT_TRIGGER  = 0;
	localparam logic [31:0] CONTROL_RST = 32'h0000_0000;

	// timing: pll reset hold after hardware reset release, in cycles
	localparam int unsigned PLL_HOLD_CYCLES = 8;
	localparam int unsigned PLL_CNT_W       = 8;
endpackage

// File: core/rscd_sync.sv
`timescale 1ns/10ps
module rscd_sync #(
	parameter int unsigned WIDTH   = 1,
	parameter logic        RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	// asynchronous in, filtered out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} rscd_sync_state_t;

	rscd_sync_state_t st_reg;
	rscd_sync_state_t st_next;

	if (WIDTH < 1) begin : g_width_check
		$error("rscd_sync: WIDTH must be at least 1");
	end

	always_comb begin
		st_next = st_reg;
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// a bit changes only once stages two and three agree
		for (int i = 0; i < WIDTH; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.lvl[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= {4{{WIDTH{RST_VAL}}}};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign level_out = st_reg.lvl;
endmodule // rscd_sync

// File: core/rscd_decode.sv
`timescale 1ns/10ps
module rscd_decode (
	// candidate straps, before latching
	input  wire logic [15:0] strap_low,
	input  wire logic [15:0] strap_high,
	// decoded configuration
	output logic             reference_crystal_25mhz,
	output logic             autostart,
	output logic [1:0]       op_mode,
	output logic [4:0]       submode,
	output logic [1:0]       led_mode,
	output logic             p5_force_link,
	output logic             p5_enable,
	output logic             rx_delay_2ns,
	output logic             tx_delay_2ns,
	output logic             sgmii_2g5,
	output logic             spi_sdi_fall,
	output logic             spi_sdo_fall,
	output logic [4:0]       mdio_addr
);
	function automatic logic is_managed(input logic [1:0] md);
		return (md == rscd_pkg::OPMD_SPI) || (md == rscd_pkg::OPMD_MDIO);
	endfunction

	function automatic logic [4:0] mdio_map(input logic [1:0] sel);
		case (sel)
			2'h0:    mdio_map = rscd_pkg::MDIO_ADDR_0;
			2'h1:    mdio_map = rscd_pkg::MDIO_ADDR_1;
			2'h2:    mdio_map = rscd_pkg::MDIO_ADDR_2;
			default: mdio_map = rscd_pkg::MDIO_ADDR_3;
		endcase
	endfunction

	logic unmanaged;
	logic managed;

	always_comb begin
		reference_crystal_25mhz = strap_low[rscd_pkg::REFERENCE_CRYSTAL_BIT];
		autostart  = strap_high[rscd_pkg::NOWAIT_BIT];
		op_mode    = {strap_low[rscd_pkg::MODE1_BIT],
		              strap_high[rscd_pkg::MODE0_BIT]};
		submode    = {strap_low[rscd_pkg::SUB4_BIT],
		              strap_low[rscd_pkg::SUB3_BIT],
		              strap_high[rscd_pkg::SUB2_BIT],
		              strap_high[rscd_pkg::SUB1_BIT],
		              strap_high[rscd_pkg::SUB0_BIT]};
		unmanaged  = (op_mode == rscd_pkg::OPMD_UNMANAGED);
		managed    = is_managed(op_mode);
		led_mode      = unmanaged ? submode[4:3] : 2'h0;
		p5_force_link = unmanaged & submode[2];
		p5_enable     = unmanaged & submode[0];
		rx_delay_2ns  = managed & submode[4];
		tx_delay_2ns  = managed & submode[3];
		sgmii_2g5     = managed & submode[2];
		spi_sdi_fall  = (op_mode == rscd_pkg::OPMD_SPI) & submode[1];
		spi_sdo_fall  = (op_mode == rscd_pkg::OPMD_SPI) & submode[0];
		mdio_addr     = (op_mode == rscd_pkg::OPMD_MDIO) ?
		                mdio_map(submode[1:0]) : 5'h00;
	end
endmodule // rscd_decode

// File: core/rscd_top.sv
`timescale 1ns/10ps
// Function
// - sample all strap pins as hardware reset rises; latch in two registers
// - strap registers cleared by hardware reset and also by the apb reset presetn
// - switch off strap pull-ups once hardware reset is released
// - hold pll reset several cycles after hardware reset rises
// - low register: crystal bit 3, mode bit1 at 7, submode 3,4 at 8,9
// - high register: no-wait 10, mode bit0 11, submode 0..2 at 12..14
// - crystal strap 0 means 40 MHz, 1 means 25 MHz
// - no-wait 0 waits for master trigger, 1 starts after initialisation
// - mode 00 reserved, 01 unmanaged, 10 spi managed, 11 mdio managed
// - unmanaged: submode 4:3 select led display mode 0 to 3
// - unmanaged: submode 2 auto-polls or forces fifth port link at 1G
// - unmanaged: submode 0 enables fifth port; submode 1 reserved
// - managed: submode 4 sets receive delay 0 or 2 ns
// - managed: submode 3 sets transmit delay 0 or 2 ns
// - managed: submode 2 selects serdes 1 or 2.5 Gbps, mac mode, no autoneg
// - spi managed: submode 1 picks slave sampling edge, 0 rise 1 fall
// - spi managed: submode 0 picks slave driving edge, 0 rise 1 fall
// - mdio managed: submode 1:0 give slave address 0, 4, 16, 31
module rscd_top #(
	parameter int unsigned PLL_HOLD = rscd_pkg::PLL_HOLD_CYCLES
) (
	// apb clock, reset and enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// hardware reset pin and shared strap pins
	input  wire logic        hw_reset_n,
	input  wire logic        uart_tx_pin,
	input  wire logic        spi_master_dout_pin,
	input  wire logic        spi_master_clk_pin,
	input  wire logic        spi_master_cs_pin,
	input  wire logic        port0_lamp2_pin,
	input  wire logic        port1_lamp2_pin,
	input  wire logic        port2_lamp2_pin,
	input  wire logic        port3_lamp2_pin,
	input  wire logic        port4_lamp2_pin,
	output logic             strap_pullup_en,
	// boot sequencing
	input  wire logic        boot_init_done,
	output logic             pll_reset_n,
	output logic             boot_start,
	// decoded configuration
	output logic             reference_crystal_25mhz,
	output logic             boot_autostart,
	output logic [1:0]       operating_mode_select,
	output logic [4:0]       submode_select,
	output logic [1:0]       led_display_mode,
	output logic             p5_force_link,
	output logic             p5_enable,
	output logic             rx_delay_2ns,
	output logic             tx_delay_2ns,
	output logic             sgmii_2g5,
	output logic             spi_sdi_fall,
	output logic             spi_sdo_fall,
	output logic [4:0]       mdio_addr
);
	////////////////////////////////////////////////////////////////////////
	// elaboration checks

	localparam int unsigned CW = rscd_pkg::PLL_CNT_W;

	if (PLL_HOLD < 1 || PLL_HOLD >= (1 << CW)) begin : g_hold_check
		$error("rscd_top: PLL_HOLD out of range");
	end

	localparam logic [CW-1:0] HOLD_LAST = CW'(PLL_HOLD - 1);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic                                   hw_lvl;
	logic [rscd_pkg::PIN_COUNT-1:0]         pins_raw;
	logic [rscd_pkg::PIN_COUNT-1:0]         pins_lvl;

	assign pins_raw = {port4_lamp2_pin, port3_lamp2_pin, port2_lamp2_pin,
	                   port1_lamp2_pin, port0_lamp2_pin, spi_master_cs_pin,
	                   spi_master_clk_pin, spi_master_dout_pin,
	                   uart_tx_pin};

	rscd_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b0)
	) u_hw_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.async_in  (hw_reset_n),
		.level_out (hw_lvl)
	);

	// same latency as the reset path, so pins line up with its edge
	rscd_sync #(
		.WIDTH   (rscd_pkg::PIN_COUNT),
		.RST_VAL (1'b0)
	) u_pin_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.async_in  (pins_raw),
		.level_out (pins_lvl)
	);

	////////////////////////////////////////////////////////////////////////
	// strap word assembly and decode of the candidate value

	logic [15:0] cand_low;
	logic [15:0] cand_high;

	always_comb begin
		cand_low  = rscd_pkg::STRAP_RST;
		cand_high = rscd_pkg::STRAP_RST;
		cand_low[rscd_pkg::REFERENCE_CRYSTAL_BIT]    = pins_lvl[0];
		cand_low[rscd_pkg::MODE1_BIT]   = pins_lvl[1];
		cand_low[rscd_pkg::SUB3_BIT]    = pins_lvl[2];
		cand_low[rscd_pkg::SUB4_BIT]    = pins_lvl[3];
		cand_high[rscd_pkg::NOWAIT_BIT] = pins_lvl[4];
		cand_high[rscd_pkg::MODE0_BIT]  = pins_lvl[5];
		cand_high[rscd_pkg::SUB0_BIT]   = pins_lvl[6];
		cand_high[rscd_pkg::SUB1_BIT]   = pins_lvl[7];
		cand_high[rscd_pkg::SUB2_BIT]   = pins_lvl[8];
	end

	logic       d_reference_crystal;
	logic       d_auto;
	logic [1:0] d_opmd;
	logic [4:0] d_sub;
	logic [1:0] d_led;
	logic       d_force;
	logic       d_p5en;
	logic       d_rxd;
	logic       d_txd;
	logic       d_2g5;
	logic       d_sdi;
	logic       d_sdo;
	logic [4:0] d_mdio;

	rscd_decode u_decode (
		.strap_low     (cand_low),
		.strap_high    (cand_high),
		.reference_crystal_25mhz    (d_reference_crystal),
		.autostart     (d_auto),
		.op_mode       (d_opmd),
		.submode       (d_sub),
		.led_mode      (d_led),
		.p5_force_link (d_force),
		.p5_enable     (d_p5en),
		.rx_delay_2ns  (d_rxd),
		.tx_delay_2ns  (d_txd),
		.sgmii_2g5     (d_2g5),
		.spi_sdi_fall  (d_sdi),
		.spi_sdo_fall  (d_sdo),
		.mdio_addr     (d_mdio)
	);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic           hw_prev;
		logic [15:0]    strap_low;
		logic [15:0]    strap_high;
		logic           captured;
		logic           pullup_en;
		logic [CW-1:0]  pll_cnt;
		logic           pll_run;
		logic           trigger;
		logic           boot;
		logic           reference_crystal;
		logic           autost;
		logic [1:0]     opmd;
		logic [4:0]     sub;
		logic [1:0]     led;
		logic           force_lnk;
		logic           p5en;
		logic           rxd;
		logic           txd;
		logic           g2g5;
		logic           sdi;
		logic           sdo;
		logic [4:0]     mdio;
		logic           rd_loaded;
		logic [31:0]    rdata;
		logic           rerr;
	} rscd_state_t;

	rscd_state_t st_reg;
	rscd_state_t st_next;

	logic rise;
	logic access_done;
	logic [31:0] rd_mux;
	logic rd_bad;

	assign rise        = hw_lvl & ~st_reg.hw_prev;
	assign pready      = psel & penable & st_reg.rd_loaded & ce;
	assign access_done = pready;

	////////////////////////////////////////////////////////////////////////
	// register read mux

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_bad = 1'b0;
		case (paddr)
			rscd_pkg::OFS_STRAP_LOW:  rd_mux[15:0] = st_reg.strap_low;
			rscd_pkg::OFS_STRAP_HIGH: rd_mux[15:0] = st_reg.strap_high;
			rscd_pkg::OFS_STATUS: begin
				rd_mux[rscd_pkg::ST_CAPTURED] = st_reg.captured;
				rd_mux[rscd_pkg::ST_PLL_RUN]  = st_reg.pll_run;
				rd_mux[rscd_pkg::ST_PULLUP]   = st_reg.pullup_en;
				rd_mux[rscd_pkg::ST_BOOT]     = st_reg.boot;
				rd_mux[rscd_pkg::ST_RESV_MD]  = st_reg.captured &
					(st_reg.opmd == rscd_pkg::OPMD_RESERVED);
				rd_mux[rscd_pkg::ST_HW_LEVEL] = hw_lvl;
			end
			rscd_pkg::OFS_CONTROL: rd_mux[rscd_pkg::CT_TRIGGER] = st_reg.trigger;
			rscd_pkg::OFS_CONFIG: begin
				rd_mux[1:0]   = st_reg.opmd;
				rd_mux[6:2]   = st_reg.sub;
				rd_mux[7]     = st_reg.reference_crystal;
				rd_mux[8]     = st_reg.autost;
				rd_mux[14:10] = st_reg.mdio;
			end
			default: rd_bad = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next = st_reg;
		st_next.hw_prev = hw_lvl;

		// apb: read data is loaded in the setup cycle, answered next
		if (psel && !st_reg.rd_loaded) begin
			st_next.rd_loaded = 1'b1;
			st_next.rdata     = pwrite ? 32'h0000_0000 : rd_mux;
			st_next.rerr      = rd_bad;
		end
		if (access_done) begin
			st_next.rd_loaded = 1'b0;
			if (pwrite && paddr == rscd_pkg::OFS_CONTROL &&
			    pwdata[rscd_pkg::CT_TRIGGER]) begin
				st_next.trigger = 1'b1;
			end
		end

		if (!hw_lvl) begin
			// hardware reset held: straps clear, pll held, pulls on
			st_next.strap_low  = rscd_pkg::STRAP_RST;
			st_next.strap_high = rscd_pkg::STRAP_RST;
			st_next.captured   = 1'b0;
			st_next.pullup_en  = 1'b1;
			st_next.pll_cnt    = '0;
			st_next.pll_run    = 1'b0;
			st_next.trigger    = 1'b0;
			st_next.boot       = 1'b0;
			st_next.reference_crystal       = 1'b0;
			st_next.autost     = 1'b0;
			st_next.opmd       = rscd_pkg::OPMD_RESERVED;
			st_next.sub        = 5'h00;
			st_next.led        = 2'h0;
			st_next.force_lnk  = 1'b0;
			st_next.p5en       = 1'b0;
			st_next.rxd        = 1'b0;
			st_next.txd        = 1'b0;
			st_next.g2g5       = 1'b0;
			st_next.sdi        = 1'b0;
			st_next.sdo        = 1'b0;
			st_next.mdio       = 5'h00;
		end else if (rise) begin
			st_next.strap_low  = cand_low;
			st_next.strap_high = cand_high;
			st_next.captured   = 1'b1;
			st_next.pullup_en  = 1'b0;
			// decoded values frozen here until hardware reset is asserted again
			st_next.reference_crystal       = d_reference_crystal;
			st_next.autost     = d_auto;
			st_next.opmd       = d_opmd;
			st_next.sub        = d_sub;
			st_next.led        = d_led;
			st_next.force_lnk  = d_force;
			st_next.p5en       = d_p5en;
			st_next.rxd        = d_rxd;
			st_next.txd        = d_txd;
			st_next.g2g5       = d_2g5;
			st_next.sdi        = d_sdi;
			st_next.sdo        = d_sdo;
			st_next.mdio       = d_mdio;
		end else if (st_reg.captured) begin
			if (!st_reg.pll_run) begin
				if (st_reg.pll_cnt == HOLD_LAST) begin
					st_next.pll_run = 1'b1;
				end else begin
					st_next.pll_cnt = st_reg.pll_cnt + 1'b1;
				end
			end
			if (st_reg.pll_run && !st_reg.boot) begin
				if (st_reg.autost ? boot_init_done : st_reg.trigger) begin
					st_next.boot = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg           <= '0;
			st_reg.pullup_en <= 1'b1;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata                = st_reg.rdata;
	assign pslverr               = pready & st_reg.rerr;
	assign strap_pullup_en       = st_reg.pullup_en;
	assign pll_reset_n           = st_reg.pll_run;
	assign boot_start            = st_reg.boot;
	assign reference_crystal_25mhz            = st_reg.reference_crystal;
	assign boot_autostart        = st_reg.autost;
	assign operating_mode_select = st_reg.opmd;
	assign submode_select        = st_reg.sub;
	assign led_display_mode      = st_reg.led;
	assign p5_force_link         = st_reg.force_lnk;
	assign p5_enable             = st_reg.p5en;
	assign rx_delay_2ns          = st_reg.rxd;
	assign tx_delay_2ns          = st_reg.txd;
	assign sgmii_2g5             = st_reg.g2g5;
	assign spi_sdi_fall          = st_reg.sdi;
	assign spi_sdo_fall          = st_reg.sdo;
	assign mdio_addr             = st_reg.mdio;
endmodule // rscd_top

// File: verification/rscd_properties.sv
`timescale 1ns/10ps
module rscd_properties #(
	parameter int unsigned PLL_HOLD = 8
) (
	// clock, reset and bus handshake
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       ce,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	// straps and boot
	input wire logic       hw_reset_n,
	input wire logic       strap_pullup_en,
	input wire logic       pll_reset_n,
	input wire logic       boot_init_done,
	input wire logic       boot_start,
	// decoded configuration
	input wire logic       reference_crystal_25mhz,
	input wire logic       boot_autostart,
	input wire logic [1:0] operating_mode_select,
	input wire logic [4:0] submode_select,
	input wire logic [1:0] led_display_mode,
	input wire logic       p5_force_link,
	input wire logic       p5_enable,
	input wire logic       rx_delay_2ns,
	input wire logic       tx_delay_2ns,
	input wire logic       sgmii_2g5,
	input wire logic       spi_sdi_fall,
	input wire logic       spi_sdo_fall,
	input wire logic [4:0] mdio_addr
);
	////////////////////////////////////////////////////////////////////////
	// cycles since capture while the pll is still held
	logic [7:0] hold_cnt_reg;
	logic [7:0] hold_cnt_next;
	always_comb begin
		hold_cnt_next = hold_cnt_reg;
		if (strap_pullup_en)
			hold_cnt_next = 8'h00;
		else if (!pll_reset_n && hold_cnt_reg != 8'hFF)
			hold_cnt_next = hold_cnt_reg + 8'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_cnt_reg <= 8'h00;
		else
			hold_cnt_reg <= hold_cnt_next;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable && ce;
	endsequence
	sequence apb_access;
		psel && penable && ce;
	endsequence
	pll_hold_time_a: assert property (
		$rose(pll_reset_n) |-> hold_cnt_reg == PLL_HOLD)
		else $error("pll released after wrong hold");
	pll_gated_a: assert property (strap_pullup_en |-> !pll_reset_n)
		else $error("pll running before capture");
	pullup_off_a: assert property (hw_reset_n [*8] |-> !strap_pullup_en)
		else $error("strap pull-ups still on");
	config_frozen_a: assert property (
		!strap_pullup_en && !$past(strap_pullup_en) |->
		$stable(operating_mode_select) && $stable(submode_select) &&
		$stable(reference_crystal_25mhz) && $stable(boot_autostart))
		else $error("decoded configuration moved");
	led_mode_a: assert property (
		operating_mode_select == 2'h1 |->
		led_display_mode == submode_select[4:3])
		else $error("led mode decode wrong");
	fifth_port_a: assert property (
		operating_mode_select == 2'h1 |->
		p5_force_link == submode_select[2] && p5_enable == submode_select[0])
		else $error("fifth port decode wrong");
	rgmii_delay_a: assert property (
		operating_mode_select[1] |->
		{rx_delay_2ns, tx_delay_2ns, sgmii_2g5} == submode_select[4:2])
		else $error("managed delay decode wrong");
	spi_edge_a: assert property (
		operating_mode_select == 2'h2 |->
		{spi_sdi_fall, spi_sdo_fall} == submode_select[1:0])
		else $error("spi edge decode wrong");
	mdio_addr_a: assert property (
		operating_mode_select == 2'h3 |-> mdio_addr ==
		(submode_select[1] ? (submode_select[0] ? 5'h1F : 5'h10) :
		(submode_select[0] ? 5'h04 : 5'h00)))
		else $error("management address decode wrong");
	boot_auto_a: assert property (
		pll_reset_n && boot_autostart && boot_init_done && !boot_start |->
		##[1:2] boot_start)
		else $error("autostart boot did not begin");
	apb_ready_a: assert property (apb_setup ##1 apb_access |-> pready)
		else $error("apb access not answered");
endmodule // rscd_properties

bind rscd_top rscd_properties #(.PLL_HOLD(PLL_HOLD)) u_rscd_properties (
	.pclk, .presetn, .ce, .psel, .penable, .pready, .hw_reset_n,
	.strap_pullup_en, .pll_reset_n, .boot_init_done, .boot_start,
	.reference_crystal_25mhz, .boot_autostart, .operating_mode_select, .submode_select,
	.led_display_mode, .p5_force_link, .p5_enable, .rx_delay_2ns,
	.tx_delay_2ns, .sgmii_2g5, .spi_sdi_fall, .spi_sdo_fall, .mdio_addr);

// File: verification/rscd_pull_model.sv
`timescale 1ns/10ps
module rscd_pull_model (
	// clock and pull-up control from the device
	input wire logic       pclk,
	input wire logic       strap_pullup_en,
	// board strap levels
	input wire logic [8:0] level,
	// shared pins
	output logic     [8:0] pins
);
	// resistors set the level while sampled; afterwards the pins carry
	// functional traffic that must not reach the latched straps
	initial pins = 9'h000;
	always @(posedge pclk) begin
		if (strap_pullup_en)
			pins <= level;
		else
			pins <= ~pins;
	end
endmodule // rscd_pull_model

// File: verification/rscd_bench.sv
`timescale 1ns/10ps
module rscd_bench;
	localparam int unsigned HOLD = 3;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        err, hw_reset_n, strap_pullup_en, boot_init_done;
	logic        pll_reset_n, boot_start, reference_crystal_25mhz, boot_autostart;
	logic [8:0]  level, pins, s;
	logic [1:0]  operating_mode_select, led_display_mode;
	logic [4:0]  submode_select, mdio_addr;
	logic        p5_force_link, p5_enable, rx_delay_2ns, tx_delay_2ns;
	logic        sgmii_2g5, spi_sdi_fall, spi_sdo_fall, init;
	logic [22:0] got, e;
	int          err_total, compares;
	assign got = {reference_crystal_25mhz, boot_autostart, operating_mode_select,
		submode_select, led_display_mode, p5_force_link, p5_enable,
		rx_delay_2ns, tx_delay_2ns, sgmii_2g5, spi_sdi_fall, spi_sdo_fall,
		mdio_addr};
	rscd_pull_model u_rscd_pull_model (.pclk(pclk),
		.strap_pullup_en(strap_pullup_en), .level(level), .pins(pins));
	rscd_top #(.PLL_HOLD(HOLD)) u_rscd_top (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .hw_reset_n(hw_reset_n), .uart_tx_pin(pins[0]),
		.spi_master_dout_pin(pins[1]), .spi_master_clk_pin(pins[2]),
		.spi_master_cs_pin(pins[3]), .port0_lamp2_pin(pins[4]),
		.port1_lamp2_pin(pins[5]), .port2_lamp2_pin(pins[6]),
		.port3_lamp2_pin(pins[7]), .port4_lamp2_pin(pins[8]),
		.strap_pullup_en(strap_pullup_en), .boot_init_done(boot_init_done),
		.pll_reset_n(pll_reset_n), .boot_start(boot_start),
		.reference_crystal_25mhz(reference_crystal_25mhz), .boot_autostart(boot_autostart),
		.operating_mode_select(operating_mode_select),
		.submode_select(submode_select), .led_display_mode(led_display_mode),
		.p5_force_link(p5_force_link), .p5_enable(p5_enable),
		.rx_delay_2ns(rx_delay_2ns), .tx_delay_2ns(tx_delay_2ns),
		.sgmii_2g5(sgmii_2g5), .spi_sdi_fall(spi_sdi_fall),
		.spi_sdo_fall(spi_sdo_fall), .mdio_addr(mdio_addr));
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(bit wr, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk("apb wait", 32'h1, 32'(n));
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// reference decode, field order matches got
	function automatic logic [22:0] expect_cfg(logic [8:0] v);
		int addr[4] = '{0, 4, 16, 31};
		logic [1:0] m;
		logic [4:0] u;
		logic [22:0] e;
		m = {v[1], v[5]};
		u = {v[3], v[2], v[8], v[7], v[6]};
		e = {v[0], v[4], m, u, 14'h0};
		if (m == 2'h1) e[13:10] = {u[4:3], u[2], u[0]};
		if (m[1]) e[9:7] = u[4:2];
		if (m == 2'h2) e[6:5] = u[1:0];
		if (m == 2'h3) e[4:0] = 5'(addr[u[1:0]]);
		return e;
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		#(100 * 20000);
		err_total++;
		close_out();
	end
	initial begin
		{psel, penable, pwrite, boot_init_done} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		ce = 1'b1;
		hw_reset_n = 1'b1;
		level = 9'h000;
		presetn = 1'b0;
		void'($urandom(92));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			s = 9'($urandom);
			s[1] = i[1];
			s[5] = i[0];
			init = 1'($urandom);
			@(posedge pclk);
			hw_reset_n <= 1'b0;
			level <= s;
			boot_init_done <= init;
			repeat (8) @(posedge pclk);
			apb(1'b0, rscd_pkg::OFS_STRAP_LOW, 32'h0);
			chk("strap low in reset", 32'h0, rd);
			@(posedge pclk);
			hw_reset_n <= 1'b1;
			for (int n = 0; n < 40 && pll_reset_n !== 1'b1; n++)
				@(posedge pclk);
			chk("pll release", 32'h1, {31'h0, pll_reset_n});
			chk("pull-up", 32'h0, {31'h0, strap_pullup_en});
			chk("decode", 32'(expect_cfg(s)), 32'(got));
			apb(1'b1, rscd_pkg::OFS_STRAP_LOW, 32'hFFFF_FFFF);
			apb(1'b0, rscd_pkg::OFS_STRAP_LOW, 32'h0);
			chk("strap low", {22'h0, s[3:1], 3'h0, s[0], 3'h0}, rd);
			apb(1'b0, rscd_pkg::OFS_STRAP_HIGH, 32'h0);
			chk("strap high", {17'h0, s[8:4], 10'h0}, rd);
			repeat (3) @(posedge pclk);
			chk("boot start", {31'h0, s[4] & init}, {31'h0, boot_start});
			apb(1'b1, rscd_pkg::OFS_CONTROL, 32'h0000_0001);
			repeat (3) @(posedge pclk);
			chk("boot trigger", {31'h0, s[4] ? init : 1'b1},
				{31'h0, boot_start});
			chk("decode held", 32'(expect_cfg(s)), 32'(got));
			e = expect_cfg(s);
			apb(1'b0, rscd_pkg::OFS_CONFIG, 32'h0);
			chk("config reg", {17'h0, e[4:0], 1'b0, e[21], e[22],
				e[18:14], e[20:19]}, rd);
			apb(1'b0, rscd_pkg::OFS_STATUS, 32'h0);
			chk("status reg", {26'h0, 1'b1, ~(s[1] | s[5]),
				s[4] ? init : 1'b1, 3'h3}, rd);
			apb(1'b0, rscd_pkg::OFS_CONTROL, 32'h0);
			chk("control reg", 32'h1, rd);
			$display("test %0d done", i);
		end
		// a hardware reset pulse while the clock enable is low is not seen
		@(posedge pclk);
		ce <= 1'b0;
		hw_reset_n <= 1'b0;
		repeat (6) @(posedge pclk);
		hw_reset_n <= 1'b1;
		@(posedge pclk);
		ce <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("decode frozen", 32'(expect_cfg(s)), 32'(got));
		chk("pll frozen", 32'h1, {31'h0, pll_reset_n});
		$display("test clock enable done");
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("test unmapped done");
		close_out();
	end
endmodule // rscd_bench
